/* design/ata_task_file_registers.sv */
/*
  Drive-side task file registers of a parallel ATA interface: data port,
  device control, drive address readback, unit/head, error, features and
  sector count. Host strobes are one-cycle pulses synchronous to clk_in;
  the drive core supplies buffer words, head and write-gate state and
  command results.
*/
// Overview of operation
// - Data port moves 16-bit words, ECC bytes 8-bit; byte mode narrows writes only, reads stay 16-bit
// - Data moves only by PIO strobes, no DMA
// - Data valid only while transfer request set
// - Data port also carries format and identify blocks
// - Control bits 7,2,1; command write clears bit 7
// - Device held in reset while soft reset set
// - Interrupt enabled only if enabled and selected
// - Readback bit 7 reads 0; bits 15:8 never driven
// - Write gate bit low while writing medium
// - Four readback bits give inverted head number
// - Low readback bits are active-low unit selects
// - Unit/head bits 7,5 one; bit 6 LBA
// - Unit/head bit 4 selects unit 0 or 1
// - Low four bits: head or LBA 24-27, updated
// - Error bit 7 CRC; bits 5,3 zero
// - Error bits report UNCORRECTABLE_ERR, SECTOR_ID_MISSING, CMD_ABORTED, TK0, ADDR_MARK_MISSING
// - Error register valid after every command
// - Diagnostic code loaded after reset, diagnostic
// - Features value interpreted per command
// - Zero sector count means 256 or 65536
// - Sector count zero on success, else remainder
// - Route access by selects, address and strobes
// - 48-bit registers keep current and previous byte
// - Transfer request only when a word can move
`timescale 1ns/1ps

module ata_task_file_registers #(
  parameter logic UNIT_ID = 1'b0
) (
  input  wire logic                      clk_in,
  input  wire logic                      soft_reset_bit_in,
  input  wire logic                      ce_in,
  input  wire ata_tf_pkg::host_req_t     host_req_in,
  output logic [15:0]                    host_rdata_out,
  output logic                           host_rdata_oe_out,
  output logic                           host_rdata_hi_oe_out,
  input  wire logic                      transfer_request_in,
  input  wire logic [15:0]               buf_rdata_in,
  output logic                           buf_rd_out,
  output logic [15:0]                    buf_wdata_out,
  output logic                           buf_wr_out,
  input  wire logic                      write_gate_n_in,
  input  wire logic [3:0]                cur_head_in,
  input  wire ata_tf_pkg::cmd_status_t   cmd_status_in,
  input  wire logic                      irq_pending_in,
  output logic                           irq_out,
  output logic                           core_reset_out,
  output logic                           cmd_strobe_out,
  output logic [7:0]                     cmd_code_out,
  output logic [7:0]                     features_out,
  output logic [7:0]                     features_prev_out,
  output logic [16:0]                    sector_total_out,
  output logic                           lba_mode_out,
  output logic                           unit_selected_out
);

  // ==========================================================================
  // Decode
  // ==========================================================================
  function automatic logic cmd_hit(input ata_tf_pkg::host_req_t r, input logic [2:0] a);
    cmd_hit = r.cs0 && !r.cs1 && (r.da == a);
  endfunction : cmd_hit

  function automatic logic ctl_hit(input ata_tf_pkg::host_req_t r, input logic [2:0] a);
    ctl_hit = !r.cs0 && r.cs1 && (r.da == a);
  endfunction : ctl_hit

  ata_tf_pkg::tf_state_t state_ff;
  ata_tf_pkg::tf_state_t nxt_state;

  logic selected;
  logic soft_rst;
  logic high_order_select;
  logic cmd_wr;
  logic any_cmd_wr;
  logic is48;

  assign selected   = (state_ff.unithd[ata_tf_pkg::UH_UNIT] == UNIT_ID);
  assign soft_rst   = state_ff.devctl[ata_tf_pkg::DC_SOFT_RESET_BIT];
  assign high_order_select        = state_ff.devctl[ata_tf_pkg::DC_HOB];
  assign cmd_wr     = host_req_in.wr && host_req_in.cs0 && !host_req_in.cs1;
  assign any_cmd_wr = cmd_wr;
  // 48-bit form is flagged by command code bits 5 and 2 both being set
  assign is48       = state_ff.cmd_code[2] && state_ff.cmd_code[5];

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    nxt_state            = state_ff;
    nxt_state.rvalid     = 1'b0;
    nxt_state.wvalid     = 1'b0;
    nxt_state.cmd_strobe = 1'b0;

    // Host writes; device control reachable even while in soft reset
    if (host_req_in.wr && ctl_hit(host_req_in, ata_tf_pkg::CTL_DEVCTL))
    begin
      nxt_state.devctl = host_req_in.wdata[7:0] & 8'h86;
    end
    if (any_cmd_wr)
    begin
      nxt_state.devctl[ata_tf_pkg::DC_HOB] = 1'b0;
    end

    if (cmd_wr && !soft_rst)
    begin
      unique case (host_req_in.da)
        ata_tf_pkg::CMD_DATA:
        begin
          if (selected && transfer_request_in)
          begin
            nxt_state.wword  = host_req_in.byte_mode ? {8'h00, host_req_in.wdata[7:0]}
                                                     : host_req_in.wdata;
            nxt_state.wvalid = 1'b1;
          end
        end
        ata_tf_pkg::CMD_ERRFT:
        begin
          nxt_state.feat_prev = state_ff.feat;
          nxt_state.feat      = host_req_in.wdata[7:0];
        end
        ata_tf_pkg::CMD_SECCNT:
        begin
          nxt_state.seccnt_prev = state_ff.seccnt;
          nxt_state.seccnt      = host_req_in.wdata[7:0];
        end
        ata_tf_pkg::CMD_UNITHD:
        begin
          // Unit select is latched by both units; only the selected one acts
          nxt_state.unithd_prev = state_ff.unithd;
          nxt_state.unithd = host_req_in.wdata[7:0] | ata_tf_pkg::UNITHD_FIXED;
        end
        ata_tf_pkg::CMD_CMDREG:
        begin
          if (selected)
          begin
            nxt_state.cmd_code   = host_req_in.wdata[7:0];
            nxt_state.cmd_strobe = 1'b1;
          end
        end
        default:
        begin
        end
      endcase
    end

    // Command completion from the core
    if (cmd_status_in.done)
    begin
      nxt_state.err = cmd_status_in.err_flags & ata_tf_pkg::ERR_ZERO_MASK;
      nxt_state.seccnt = cmd_status_in.ok ? 8'h00 : cmd_status_in.sectors_left;
      nxt_state.unithd[3:0] = cmd_status_in.head_or_lba;
    end
    if (cmd_status_in.diag_load)
    begin
      nxt_state.err = cmd_status_in.diag_code;
    end

    // Host reads: data port returns a word only under transfer request
    if (host_req_in.rd && cmd_hit(host_req_in, ata_tf_pkg::CMD_DATA) && selected)
    begin
      nxt_state.rdata  = transfer_request_in ? buf_rdata_in : 16'h0000;
      nxt_state.rvalid = transfer_request_in;
    end
    else if (host_req_in.rd && selected)
    begin
      nxt_state.rdata[15:8] = 8'h00;
      if (cmd_hit(host_req_in, ata_tf_pkg::CMD_ERRFT))
        nxt_state.rdata[7:0] = state_ff.err;
      else if (cmd_hit(host_req_in, ata_tf_pkg::CMD_SECCNT))
        nxt_state.rdata[7:0] = high_order_select ? state_ff.seccnt_prev : state_ff.seccnt;
      else if (cmd_hit(host_req_in, ata_tf_pkg::CMD_UNITHD))
        nxt_state.rdata[7:0] = state_ff.unithd;
      else if (ctl_hit(host_req_in, ata_tf_pkg::CTL_DRVADR))
        nxt_state.rdata[7:0] = {1'b0, write_gate_n_in, ~cur_head_in,
                                state_ff.unithd[ata_tf_pkg::UH_UNIT] ? 2'b01 : 2'b10};
      else
        nxt_state.rdata[7:0] = 8'h00;
    end

    // Soft reset keeps the block at defaults, device control stays writable
    if (soft_rst)
    begin
      nxt_state.err         = ata_tf_pkg::DIAG_CODE_RST;
      nxt_state.seccnt      = ata_tf_pkg::SECCNT_RST;
      nxt_state.seccnt_prev = 8'h00;
      nxt_state.feat        = 8'h00;
      nxt_state.feat_prev   = 8'h00;
      nxt_state.unithd      = ata_tf_pkg::UNITHD_RST;
      nxt_state.unithd_prev = ata_tf_pkg::UNITHD_RST;
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_in)
  begin
    if (soft_reset_bit_in)
    begin
      state_ff        <= '0;
      state_ff.devctl <= ata_tf_pkg::DEVCTL_RST;
      state_ff.unithd <= ata_tf_pkg::UNITHD_RST;
      state_ff.unithd_prev <= ata_tf_pkg::UNITHD_RST;
      state_ff.seccnt <= ata_tf_pkg::SECCNT_RST;
      state_ff.err    <= ata_tf_pkg::DIAG_CODE_RST;
    end
    else if (ce_in)
    begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Bits 15:8 of the drive address readback are left floating; bit 7 reads 0
  logic drvadr_rd;
  assign drvadr_rd = host_req_in.rd && ctl_hit(host_req_in, ata_tf_pkg::CTL_DRVADR);

  assign host_rdata_out       = state_ff.rdata;
  assign host_rdata_oe_out    = host_req_in.rd && selected && !(host_req_in.cs0 && host_req_in.cs1)
                                && (host_req_in.cs0 || host_req_in.cs1);
  assign host_rdata_hi_oe_out = host_rdata_oe_out && !drvadr_rd;

  assign buf_rd_out    = state_ff.rvalid;
  assign buf_wdata_out = state_ff.wword;
  assign buf_wr_out    = state_ff.wvalid;

  assign irq_out = irq_pending_in && selected && !state_ff.devctl[ata_tf_pkg::DC_IEN_N];
  assign core_reset_out = soft_rst || soft_reset_bit_in;

  assign cmd_strobe_out    = state_ff.cmd_strobe;
  assign cmd_code_out      = state_ff.cmd_code;
  assign features_out      = state_ff.feat;
  assign features_prev_out = state_ff.feat_prev;
  assign lba_mode_out      = state_ff.unithd[ata_tf_pkg::UH_LBA];
  assign unit_selected_out = selected;

  // Zero counts expand to the full range of the addressing form
  always_comb
  begin
    if (is48)
      sector_total_out = ({state_ff.seccnt_prev, state_ff.seccnt} == 16'h0000)
                         ? 17'(ata_tf_pkg::SEC_ZERO_48)
                         : {1'b0, state_ff.seccnt_prev, state_ff.seccnt};
    else
      sector_total_out = (state_ff.seccnt == 8'h00) ? 17'(ata_tf_pkg::SEC_ZERO_28)
                         : {9'h000, state_ff.seccnt};
  end

endmodule : ata_task_file_registers

/* design/ata_tf_pkg.sv */
/*
  Shared constants and carrier types for the ATA task file register block.
  Assumes a single 100 MHz clock domain and host strobes that are already
  synchronous to it.
*/
package ata_tf_pkg;

  // ==========================================================================
  // Bus address decode: {cs0, cs1, da[2:0]} as asserted-high selects
  // ==========================================================================
  localparam logic [2:0] CMD_DATA   = 3'h0;
  localparam logic [2:0] CMD_ERRFT  = 3'h1;
  localparam logic [2:0] CMD_SECCNT = 3'h2;
  localparam logic [2:0] CMD_UNITHD = 3'h6;
  localparam logic [2:0] CMD_CMDREG = 3'h7;
  localparam logic [2:0] CTL_DEVCTL = 3'h6;
  localparam logic [2:0] CTL_DRVADR = 3'h7;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int DC_HOB     = 7;
  localparam int DC_SOFT_RESET_BIT    = 2;
  localparam int DC_IEN_N   = 1;
  localparam int UH_LBA     = 6;
  localparam int UH_UNIT    = 4;
  localparam int ER_CRC     = 7;
  localparam int ER_UNC     = 6;
  localparam int ER_SECTOR_ID_MISSING    = 4;
  localparam int ER_CMD_ABORTED    = 2;
  localparam int ER_TK0     = 1;
  localparam int ER_ADDR_MARK_MISSING    = 0;

  // ==========================================================================
  // Reset values and fixed bits
  // ==========================================================================
  localparam logic [7:0] UNITHD_FIXED  = 8'hA0;
  localparam logic [7:0] UNITHD_RST    = 8'hA0;
  localparam logic [7:0] DEVCTL_RST    = 8'h00;
  localparam logic [7:0] SECCNT_RST    = 8'h01;
  localparam logic [7:0] DIAG_CODE_RST = 8'h01;
  localparam logic [7:0] ERR_ZERO_MASK = 8'hD7;

  // ==========================================================================
  // Timing: least soft reset hold time the host must keep
  // ==========================================================================
  localparam int SOFT_RESET_BIT_HOLD_MS  = 5;
  localparam int CLK_MHZ       = 100;
  localparam int SOFT_RESET_BIT_HOLD_CYC = SOFT_RESET_BIT_HOLD_MS * 1000 * CLK_MHZ;

  // Sector counts implied by a zero register value
  localparam int SEC_ZERO_28 = 256;
  localparam int SEC_ZERO_48 = 65536;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic       cs0;
    logic       cs1;
    logic [2:0] da;
    logic       rd;
    logic       wr;
    logic       byte_mode;
    logic [15:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic       done;
    logic       ok;
    logic [7:0] err_flags;
    logic [7:0] sectors_left;
    logic [3:0] head_or_lba;
    logic       diag_load;
    logic [7:0] diag_code;
  } cmd_status_t;

  typedef struct packed {
    logic [7:0]  devctl;
    logic [7:0]  unithd;
    logic [7:0]  unithd_prev;
    logic [7:0]  feat;
    logic [7:0]  feat_prev;
    logic [7:0]  seccnt;
    logic [7:0]  seccnt_prev;
    logic [7:0]  err;
    logic [15:0] rdata;
    logic        rvalid;
    logic [15:0] wword;
    logic        wvalid;
    logic        cmd_strobe;
    logic [7:0]  cmd_code;
  } tf_state_t;

endpackage : ata_tf_pkg

/* bench/ata_tf_checker.sv */
/*
  Port-level assertions for the task file register block.
  Assumes a bind to the top module, one clock domain and a sync reset.
*/
`timescale 1ns/1ps
module ata_tf_checker #(
  parameter logic UNIT_ID = 1'b0
) (
  input wire logic                  clk_in,
  input wire logic                  soft_reset_bit_in,
  input wire logic                  ce_in,
  input wire ata_tf_pkg::host_req_t host_req_in,
  input wire logic [15:0]           host_rdata_out,
  input wire logic                  host_rdata_oe_out,
  input wire logic                  host_rdata_hi_oe_out,
  input wire logic                  transfer_request_in,
  input wire logic [15:0]           buf_rdata_in,
  input wire logic [15:0]           buf_wdata_out,
  input wire logic                  buf_wr_out,
  input wire logic                  write_gate_n_in,
  input wire logic [3:0]            cur_head_in,
  input wire logic                  irq_pending_in,
  input wire logic                  irq_out,
  input wire logic                  core_reset_out,
  input wire logic [16:0]           sector_total_out,
  input wire logic                  lba_mode_out,
  input wire logic                  unit_selected_out
);
  // ==========================================================================
  // Decode helpers
  logic       rd_c;
  logic       wr_c;
  logic       ctl;
  logic       cmd;
  logic [2:0] da;
  assign rd_c = ce_in && host_req_in.rd;
  assign wr_c = ce_in && host_req_in.wr;
  assign ctl = host_req_in.cs1 && !host_req_in.cs0;
  assign cmd = host_req_in.cs0 && !host_req_in.cs1;
  assign da = host_req_in.da;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (soft_reset_bit_in);
  // ==========================================================================
  // Assertions
  chk_irq_gate: assert property (
    irq_out |-> irq_pending_in && unit_selected_out) else $error("irq not gated");
  chk_soft_reset_bit_hold: assert property (
    wr_c && ctl && da == ata_tf_pkg::CTL_DEVCTL && host_req_in.wdata[2]
    |=> core_reset_out [*2]) else $error("soft reset not held");
  chk_soft_reset_bit_free: assert property (
    wr_c && ctl && da == ata_tf_pkg::CTL_DEVCTL && !host_req_in.wdata[2]
    |=> !core_reset_out) else $error("soft reset not released");
  chk_both_cs: assert property (
    host_req_in.rd && host_req_in.cs0 && host_req_in.cs1 |-> !host_rdata_oe_out)
    else $error("invalid address driven");
  chk_float_bit: assert property (
    host_req_in.rd && ctl && da == ata_tf_pkg::CTL_DRVADR |-> !host_rdata_hi_oe_out)
    else $error("float bit driven");
  chk_addr_readback: assert property (
    rd_c && ctl && da == ata_tf_pkg::CTL_DRVADR && unit_selected_out
    |=> host_rdata_out[6:0] == {$past(write_gate_n_in), ~$past(cur_head_in),
                                (UNIT_ID ? 2'b01 : 2'b10)}) else $error("bad readback");
  chk_unit_lba: assert property (
    wr_c && cmd && da == ata_tf_pkg::CMD_UNITHD && !core_reset_out
    |=> lba_mode_out == $past(host_req_in.wdata[6]) &&
        unit_selected_out == ($past(host_req_in.wdata[4]) == UNIT_ID))
    else $error("unit or mode not taken");
  chk_data_wr: assert property (
    wr_c && cmd && da == ata_tf_pkg::CMD_DATA && transfer_request_in && !core_reset_out
    && unit_selected_out |=> buf_wr_out && buf_wdata_out == ($past(host_req_in.byte_mode)
    ? {8'h00, $past(host_req_in.wdata[7:0])} : $past(host_req_in.wdata)))
    else $error("data word lost");
  chk_data_rd: assert property (
    rd_c && cmd && da == ata_tf_pkg::CMD_DATA && transfer_request_in && unit_selected_out
    |=> host_rdata_out == $past(buf_rdata_in)) else $error("data word wrong");
  chk_count_range: assert property (
    sector_total_out inside {[17'h00001:17'h10000]}) else $error("sector total out of range");
  cover property (irq_out);
  cover property (buf_wr_out);
  cover property (wr_c && ctl && host_req_in.wdata[7]);
endmodule : ata_tf_checker

/* bench/ata_host_model.sv */
/*
  Host controller model: one-cycle read and write strobes on the task file.
  Assumes the block samples strobes on the rising edge of clk_in.
*/
`timescale 1ns/1ps
module ata_host_model (
  input  wire logic             clk_in,
  input  wire logic [15:0]      rdata_in,
  output ata_tf_pkg::host_req_t req_out
);
  initial req_out = '0;
  // ==========================================================================
  // One bus cycle: strobe for one edge, then release and take read data
  task automatic cyc(input logic c1, input logic [2:0] a, input logic w,
                     input logic [15:0] v, output logic [15:0] d);
    @(negedge clk_in);
    req_out.cs0 = !c1;
    req_out.cs1 = c1;
    req_out.da = a;
    req_out.wr = w;
    req_out.rd = !w;
    req_out.wdata = v;
    @(negedge clk_in);
    d = rdata_in;
    req_out.rd = 1'b0;
    req_out.wr = 1'b0;
    req_out.cs0 = 1'b0;
    req_out.cs1 = 1'b0;
    // Released bus must not look like the last word
    req_out.wdata = ~v;
  endtask : cyc
endmodule : ata_host_model

/* bench/ata_task_file_registers_bench.sv */
/*
  Self-checking bench for the task file register block.
  Assumes the host model drives strobes; bench drives core-side inputs.
*/
`timescale 1ns/1ps
module ata_task_file_registers_bench;
  logic                    clk;
  logic                    soft_reset_bit;
  logic                    treq;
  logic [15:0]             bufd;
  logic                    wgn;
  logic [3:0]              head;
  ata_tf_pkg::cmd_status_t st;
  ata_tf_pkg::host_req_t   req;
  logic                    irqp;
  logic [15:0]             rdata;
  logic [15:0]             bufwd;
  logic                    irq;
  logic                    crst;
  logic [7:0]              feat;
  logic [16:0]             stot;
  logic                    lba;
  logic                    usel;
  logic [15:0]             d;
  logic                    brd;
  logic                    cstb;
  logic [7:0]              ccode;
  logic [7:0]              fprev;
  int                      n_errors = 0;
  int                      total_checks = 0;
  ata_host_model ata_host_model_inst (.clk_in(clk), .rdata_in(rdata), .req_out(req));
  ata_task_file_registers ata_task_file_registers_inst (
    .clk_in(clk), .soft_reset_bit_in(soft_reset_bit), .ce_in(1'b1), .host_req_in(req),
    .host_rdata_out(rdata), .host_rdata_oe_out(), .host_rdata_hi_oe_out(),
    .transfer_request_in(treq), .buf_rdata_in(bufd), .buf_rd_out(brd),
    .buf_wdata_out(bufwd), .buf_wr_out(), .write_gate_n_in(wgn),
    .cur_head_in(head), .cmd_status_in(st), .irq_pending_in(irqp), .irq_out(irq),
    .core_reset_out(crst), .cmd_strobe_out(cstb), .cmd_code_out(ccode),
    .features_out(feat), .features_prev_out(fprev), .sector_total_out(stot),
    .lba_mode_out(lba),
    .unit_selected_out(usel));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic w(input logic c1, input logic [2:0] a, input logic [15:0] v);
    ata_host_model_inst.cyc(c1, a, 1'b1, v, d);
  endtask : w
  task automatic r(input logic c1, input logic [2:0] a);
    ata_host_model_inst.cyc(c1, a, 1'b0, 16'h0000, d);
  endtask : r
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    r(1'b0, ata_tf_pkg::CMD_ERRFT);
    chk(d[7:0], ata_tf_pkg::DIAG_CODE_RST);
    r(1'b0, ata_tf_pkg::CMD_UNITHD);
    chk(d[7:0], ata_tf_pkg::UNITHD_RST);
    chk(irq, 1'b1);
  endtask : t_reset
  task automatic t_select;
    w(1'b1, ata_tf_pkg::CTL_DEVCTL, 16'h0002);
    chk(irq, 1'b0);
    w(1'b1, ata_tf_pkg::CTL_DEVCTL, 16'h0000);
    w(1'b0, ata_tf_pkg::CMD_UNITHD, 16'h00B0);
    chk({usel, irq}, 2'b00);
    w(1'b0, ata_tf_pkg::CMD_UNITHD, 16'h00E0);
    chk({usel, lba, irq}, 3'b111);
  endtask : t_select
  task automatic t_hob;
    w(1'b0, ata_tf_pkg::CMD_SECCNT, 16'h0005);
    w(1'b0, ata_tf_pkg::CMD_SECCNT, 16'h0007);
    w(1'b1, ata_tf_pkg::CTL_DEVCTL, 16'h0080);
    r(1'b0, ata_tf_pkg::CMD_SECCNT);
    chk(d[7:0], 8'h05);
    w(1'b0, ata_tf_pkg::CMD_ERRFT, 16'h0011);
    chk(feat, 8'h11);
    w(1'b0, ata_tf_pkg::CMD_ERRFT, 16'h0022);
    chk(fprev, 8'h11);
    r(1'b0, ata_tf_pkg::CMD_SECCNT);
    chk(d[7:0], 8'h07);
    w(1'b0, ata_tf_pkg::CMD_SECCNT, 16'h0000);
    chk(stot, 17'(ata_tf_pkg::SEC_ZERO_28));
    // Command code with bits 5 and 2 set selects the 48-bit count form
    w(1'b0, ata_tf_pkg::CMD_CMDREG, 16'h0024);
    chk({cstb, ccode}, 9'h124);
    chk(stot, 17'h00700);
  endtask : t_hob
  task automatic t_readback;
    @(negedge clk);
    wgn = 1'b0;
    head = 4'h5;
    r(1'b1, ata_tf_pkg::CTL_DRVADR);
    chk(d[6:0], 7'h2A);
    wgn = 1'b1;
  endtask : t_readback
  task automatic t_data;
    @(negedge clk);
    treq = 1'b1;
    bufd = 16'hBEEF;
    r(1'b0, ata_tf_pkg::CMD_DATA);
    chk(d, 16'hBEEF);
    chk(brd, 1'b1);
    w(1'b0, ata_tf_pkg::CMD_DATA, 16'h1234);
    chk(bufwd, 16'h1234);
    ata_host_model_inst.req_out.byte_mode = 1'b1;
    w(1'b0, ata_tf_pkg::CMD_DATA, 16'hAB5C);
    chk(bufwd, 16'h005C);
    ata_host_model_inst.req_out.byte_mode = 1'b0;
    w(1'b0, ata_tf_pkg::CMD_DATA, 16'h1234);
    treq = 1'b0;
    w(1'b0, ata_tf_pkg::CMD_DATA, 16'h5678);
    chk(bufwd, 16'h1234);
  endtask : t_data
  task automatic t_done;
    @(negedge clk);
    st = '{1'b1, 1'b0, 8'hFF, 8'h03, 4'h9, 1'b0, 8'h00};
    @(negedge clk);
    st.done = 1'b0;
    r(1'b0, ata_tf_pkg::CMD_ERRFT);
    chk(d[7:0], ata_tf_pkg::ERR_ZERO_MASK);
    r(1'b0, ata_tf_pkg::CMD_SECCNT);
    chk(d[7:0], 8'h03);
    r(1'b0, ata_tf_pkg::CMD_UNITHD);
    chk(d[7:0], 8'hE9);
    st = '{1'b0, 1'b0, 8'h00, 8'h00, 4'h0, 1'b1, 8'h5A};
    @(negedge clk);
    st.diag_load = 1'b0;
    r(1'b0, ata_tf_pkg::CMD_ERRFT);
    chk(d[7:0], 8'h5A);
  endtask : t_done
  task automatic t_soft_reset_bit;
    w(1'b1, ata_tf_pkg::CTL_DEVCTL, 16'h0004);
    chk(crst, 1'b1);
    w(1'b0, ata_tf_pkg::CMD_SECCNT, 16'h0033);
    w(1'b1, ata_tf_pkg::CTL_DEVCTL, 16'h0000);
    chk(crst, 1'b0);
    r(1'b0, ata_tf_pkg::CMD_ERRFT);
    chk(d[7:0], ata_tf_pkg::DIAG_CODE_RST);
  endtask : t_soft_reset_bit
  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    soft_reset_bit = 1'b1;
    {treq, bufd, wgn, head, st, irqp} = '0;
    wgn = 1'b1;
    irqp = 1'b1;
    repeat (12) @(negedge clk);
    soft_reset_bit = 1'b0;
    t_reset();
    t_select();
    t_hob();
    t_readback();
    t_data();
    t_done();
    t_soft_reset_bit();
    give_verdict();
  end
  initial
  begin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule : ata_task_file_registers_bench
bind ata_task_file_registers ata_tf_checker #(.UNIT_ID(UNIT_ID)) ata_tf_checker_inst (
  .clk_in, .soft_reset_bit_in, .ce_in, .host_req_in, .host_rdata_out, .host_rdata_oe_out,
  .host_rdata_hi_oe_out, .transfer_request_in, .buf_rdata_in, .buf_wdata_out,
  .buf_wr_out, .write_gate_n_in, .cur_head_in, .irq_pending_in, .irq_out,
  .core_reset_out, .sector_total_out, .lba_mode_out, .unit_selected_out);
